// ===== ncw_ctrl.sv
// mode register write gating, page table base and receive/transmit watchdogs
`timescale 1ns/1ps
module ncw_ctrl #(
    parameter bit MODE_TOP_RESET = 1'b1
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // host register access
    input  wire ncw_pkg::ncw_csr_req_t csr_req,
    output logic [31:0]              csr_rdata,
    output logic                     csr_rvalid,
    // process states and activity
    input  wire ncw_pkg::ncw_proc_in_t proc_in,
    // effective mode settings
    output ncw_pkg::ncw_mode_t       mode,
    // watchdog events
    output logic                     rx_cutoff,
    output logic                     tx_cutoff,
    output logic                     rx_watchdog_flag,
    output logic                     tx_watchdog_flag,
    // page table base for virtual addressing
    output logic [29:0]              table_base_address,
    output logic                     table_base_valid
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic csr_hit(
        input logic [31:0] addr,
        input logic [31:0] ofs
    );
        csr_hit = (addr == ofs);
    endfunction

    function automatic logic [15:0] wd_limit(
        input logic        loaded,
        input logic [15:0] field
    );
        logic [15:0] v;
        v = loaded ? field : ncw_pkg::WD_DEFAULT;
        if (v != 16'h0000 && v < ncw_pkg::WD_MIN) begin
            v = ncw_pkg::WD_MIN;
        end
        wd_limit = v;
    endfunction

    function automatic ncw_pkg::ncw_mode_t mode_unpack(
        input logic [31:0] w
    );
        ncw_pkg::ncw_mode_t m;
        m.ie                  = w[ncw_pkg::POS_IE];
        m.burst_limit         = w[ncw_pkg::POS_BL +: 2];
        m.be                  = w[ncw_pkg::POS_BE];
        m.re                  = w[ncw_pkg::POS_RE];
        m.single_cycle_enable = w[ncw_pkg::POS_SE];
        m.dc                  = w[ncw_pkg::POS_DC];
        m.rx_start_cmd        = w[ncw_pkg::POS_SR];
        m.tx_start_cmd        = w[ncw_pkg::POS_ST];
        m.operating_mode      = w[ncw_pkg::POS_OM +: 2];
        m.force_collision     = w[ncw_pkg::POS_FC];
        m.pb                  = w[ncw_pkg::POS_PB];
        m.af                  = w[ncw_pkg::POS_AF +: 2];
        mode_unpack = m;
    endfunction

    // ****************************************
    // reset value and state
    // ****************************************
    localparam logic [31:0] MODE_RESET = MODE_TOP_RESET ?
        ncw_pkg::MODE_RESET_HI : ncw_pkg::MODE_RESET_LO;

    ncw_pkg::ncw_state_t st_reg;
    ncw_pkg::ncw_state_t st_next;
    ncw_pkg::ncw_mode_t  wr_mode;
    logic                rx_stop;
    logic                tx_stop;
    logic                wr_mode_hit;
    logic                wr_base_hit;
    logic                wr_wdog_hit;
    logic [1:0]          act;
    logic [1:0][15:0]    lim;

    // ****************************************
    // decode
    // ****************************************
    always_comb begin
        rx_stop     = (proc_in.rx_state == ncw_pkg::PS_STOPPED);
        tx_stop     = (proc_in.tx_state == ncw_pkg::PS_STOPPED);
        wr_mode     = mode_unpack(csr_req.wdata);
        wr_mode_hit = csr_req.wr && csr_hit(csr_req.addr, ncw_pkg::OFS_MODE);
        wr_base_hit = csr_req.wr && csr_hit(csr_req.addr, ncw_pkg::OFS_BASE);
        wr_wdog_hit = csr_req.wr && csr_hit(csr_req.addr, ncw_pkg::OFS_WDOG);
        act[0]      = proc_in.rx_active;
        act[1]      = proc_in.tx_active;
        lim[0]      = wd_limit(st_reg.wd_loaded[0],
                               st_reg.wdog[ncw_pkg::POS_RT +: 16]);
        lim[1]      = wd_limit(st_reg.wd_loaded[1],
                               st_reg.wdog[ncw_pkg::POS_TT +: 16]);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next        = st_reg;
        st_next.cut    = 2'b00;
        st_next.rvalid = 1'b0;

        // mode register: readback always, ie, be and re always taken, every other field gated on process state
        if (wr_mode_hit) begin
            st_next.mode_shadow = csr_req.wdata;
            st_next.eff.ie      = wr_mode.ie;
            st_next.eff.be      = wr_mode.be;
            st_next.eff.re      = wr_mode.re;
            if (rx_stop && tx_stop) begin
                st_next.eff.burst_limit         = wr_mode.burst_limit;
                st_next.eff.operating_mode      = wr_mode.operating_mode;
                st_next.eff.single_cycle_enable = wr_mode.single_cycle_enable;
            end
            if (rx_stop && tx_stop &&
                st_reg.eff.operating_mode == ncw_pkg::OM_LOOPBACK) begin
                st_next.eff.force_collision = wr_mode.force_collision;
            end
            if (rx_stop) begin
                st_next.eff.dc = wr_mode.dc;
                st_next.eff.pb = wr_mode.pb;
                st_next.eff.af = wr_mode.af;
            end
            if (wr_mode.rx_start_cmd) begin
                if (rx_stop && proc_in.rx_list_init) begin
                    st_next.eff.rx_start_cmd = 1'b1;
                end
            end else if (!rx_stop) begin
                st_next.eff.rx_start_cmd = 1'b0;
            end
            if (wr_mode.tx_start_cmd) begin
                if (tx_stop && proc_in.tx_list_init) begin
                    st_next.eff.tx_start_cmd = 1'b1;
                end
            end else if (!tx_stop) begin
                st_next.eff.tx_start_cmd = 1'b0;
            end
        end

        // page table base: only the low 30 bits are stored
        if (wr_base_hit) begin
            st_next.table_base_address = csr_req.wdata[29:0];
        end

        // watchdog fields: each takes a value only while its side is stopped
        if (wr_wdog_hit) begin
            if (rx_stop) begin
                st_next.wdog[ncw_pkg::POS_RT +: 16] =
                    csr_req.wdata[ncw_pkg::POS_RT +: 16];
                st_next.wd_loaded[0] = 1'b1;
            end
            if (tx_stop) begin
                st_next.wdog[ncw_pkg::POS_TT +: 16] =
                    csr_req.wdata[ncw_pkg::POS_TT +: 16];
                st_next.wd_loaded[1] = 1'b1;
            end
        end

        // watchdog counters, index 0 receive, 1 transmit
        for (int i = 0; i < 2; i++) begin
            st_next.act_d[i] = act[i];
            if (!act[i] || !st_reg.act_d[i]) begin
                st_next.cnt[i]     = 20'h00000;
                st_next.tripped[i] = 1'b0;
            end else if (proc_in.sclk_tick && !st_reg.tripped[i] &&
                         lim[i] != 16'h0000) begin
                st_next.cnt[i] = st_reg.cnt[i] + 20'h00001;
                if (st_next.cnt[i] == (20'(lim[i]) << ncw_pkg::WD_SHIFT)) begin
                    st_next.cut[i]     = 1'b1;
                    st_next.tripped[i] = 1'b1;
                end
            end
        end

        // page table base goes out only for virtual addressing
        st_next.base_out_valid = proc_in.desc_va;
        st_next.base_out       = proc_in.desc_va ?
                                 st_reg.table_base_address : 30'h00000000;

        // register read, answered one cycle after the request
        if (csr_req.rd) begin
            st_next.rvalid = 1'b1;
            if (csr_hit(csr_req.addr, ncw_pkg::OFS_MODE)) begin
                st_next.rdata = st_reg.mode_shadow;
            end else if (csr_hit(csr_req.addr, ncw_pkg::OFS_BASE)) begin
                st_next.rdata = {2'b00, st_reg.table_base_address};
            end else if (csr_hit(csr_req.addr, ncw_pkg::OFS_WDOG)) begin
                st_next.rdata = st_reg.wdog;
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg                    <= '0;
            st_reg.mode_shadow        <= MODE_RESET;
            st_reg.eff                <= mode_unpack(MODE_RESET);
            st_reg.table_base_address <= ncw_pkg::BASE_RESET;
            st_reg.wdog               <= ncw_pkg::WDOG_RESET;
            st_reg.wd_loaded          <= 2'b00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        csr_rdata          = st_reg.rdata;
        csr_rvalid         = st_reg.rvalid;
        mode               = st_reg.eff;
        rx_cutoff          = st_reg.cut[0];
        tx_cutoff          = st_reg.cut[1];
        rx_watchdog_flag   = st_reg.cut[0];
        tx_watchdog_flag   = st_reg.cut[1];
        table_base_address = st_reg.base_out;
        table_base_valid   = st_reg.base_out_valid;
    end

endmodule // ncw_ctrl

// ===== ncw_pkg.sv
// constants, carrier types and rule summary for the mode gate and watchdogs
// How it works
// - after reset the mode register reads one of two values, top bit differing
// - burst limit, mode and single cycle fields apply only with both processes stopped
// - force collision applies only with both stopped and internal loopback selected
// - receive start honoured only when receive stopped and its list base loaded
// - transmit start honoured only when transmit stopped and its list base loaded
// - receive stop honoured only while receive is running or suspended
// - transmit stop honoured only while transmit is running or suspended
// - a refused mode write is dropped for good, never applied later
// - the mode register reads back whatever was last written
// - page table base holds a 30-bit physical address in its low bits
// - top two bits of page table base read zero, writes ignored
// - page table base is handed out only for virtual addressing descriptors
// - receiver active for upper field times 16 serial clocks gets cut off, flagged
// - a zero written to a watchdog field disables that timer
// - receive watchdog values 1 to 44 act as 45
// - transmitter active for lower field times 16 serial clocks gets cut off, flagged
// - transmit watchdog values 1 to 44 act as 45
// - receive watchdog field is written only while receive is stopped
// - transmit watchdog field is written only while transmit is stopped
// - after reset both watchdogs run with 1250
package ncw_pkg;

    // ****************************************
    // register map and reset values
    // ****************************************
    localparam logic [31:0] OFS_MODE      = 32'h20008018;
    localparam logic [31:0] OFS_BASE      = 32'h2000801C;
    localparam logic [31:0] OFS_RSVD      = 32'h20008020;
    localparam logic [31:0] OFS_WDOG      = 32'h20008024;
    localparam logic [31:0] MODE_RESET_HI = 32'h83E0F000;
    localparam logic [31:0] MODE_RESET_LO = 32'h03E0F000;
    localparam logic [31:0] WDOG_RESET    = 32'h00000000;
    localparam logic [29:0] BASE_RESET    = 30'h00000000;

    // ****************************************
    // mode register field positions
    // ****************************************
    localparam int POS_IE = 31;
    localparam int POS_BL = 24;
    localparam int POS_BE = 23;
    localparam int POS_RE = 22;
    localparam int POS_SE = 21;
    localparam int POS_DC = 15;
    localparam int POS_SR = 11;
    localparam int POS_ST = 10;
    localparam int POS_OM = 8;
    localparam int POS_FC = 6;
    localparam int POS_PB = 3;
    localparam int POS_AF = 1;
    localparam logic [1:0] OM_LOOPBACK = 2'h1;

    // ****************************************
    // watchdog figures
    // ****************************************
    localparam int         POS_RT     = 16;
    localparam int         POS_TT     = 0;
    localparam logic [15:0] WD_DEFAULT = 16'h04E2;
    localparam logic [15:0] WD_MIN     = 16'h002D;
    localparam int         WD_SHIFT   = 4;

    // ****************************************
    // carrier types
    // ****************************************
    typedef enum logic [1:0] {
        PS_STOPPED,
        PS_RUNNING,
        PS_SUSPENDED
    } ncw_proc_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ncw_csr_req_t;

    typedef struct packed {
        ncw_proc_t rx_state;
        ncw_proc_t tx_state;
        logic      rx_list_init;
        logic      tx_list_init;
        logic      rx_active;
        logic      tx_active;
        logic      sclk_tick;
        logic      desc_va;
    } ncw_proc_in_t;

    typedef struct packed {
        logic       ie;
        logic [1:0] burst_limit;
        logic       be;
        logic       re;
        logic       single_cycle_enable;
        logic       dc;
        logic       rx_start_cmd;
        logic       tx_start_cmd;
        logic [1:0] operating_mode;
        logic       force_collision;
        logic       pb;
        logic [1:0] af;
    } ncw_mode_t;

    typedef struct packed {
        logic [31:0]      mode_shadow;
        ncw_mode_t        eff;
        logic [29:0]      table_base_address;
        logic [31:0]      wdog;
        logic [1:0]       wd_loaded;
        logic [1:0][19:0] cnt;
        logic [1:0]       act_d;
        logic [1:0]       tripped;
        logic [1:0]       cut;
        logic [31:0]      rdata;
        logic             rvalid;
        logic [29:0]      base_out;
        logic             base_out_valid;
    } ncw_state_t;

endpackage

// ===== ncw_host_model.sv
// host side model issuing longword register cycles
`timescale 1ns/1ps
module ncw_host_model (
    // clock
    input  wire logic                  clk,
    // register cycles
    output ncw_pkg::ncw_csr_req_t      req,
    input  wire logic [31:0]           rdata,
    input  wire logic                  rvalid
);
    initial req = '0;
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        ok = rvalid;
        d = rdata;
    endtask
endmodule // ncw_host_model

// ===== ncw_ctrl_props.sv
// checker for mode gating, page base and watchdog outputs
`timescale 1ns/1ps
module ncw_ctrl_props (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst_b,
    // host access
    input wire ncw_pkg::ncw_csr_req_t csr_req,
    input wire logic [31:0]           csr_rdata,
    input wire logic                  csr_rvalid,
    // process side
    input wire ncw_pkg::ncw_proc_in_t proc_in,
    input wire ncw_pkg::ncw_mode_t    mode,
    input wire logic                  rx_cutoff,
    input wire logic                  tx_cutoff,
    input wire logic                  rx_watchdog_flag,
    input wire logic                  tx_watchdog_flag,
    input wire logic [29:0]           table_base_address,
    input wire logic                  table_base_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic wm = csr_req.wr && csr_req.addr == ncw_pkg::OFS_MODE;
    property p_rvalid; csr_rvalid == $past(csr_req.rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer late");
    property p_top; csr_req.rd && csr_req.addr == ncw_pkg::OFS_BASE
        |=> csr_rdata[31:30] == 2'h0; endproperty
    a_top: assert property (p_top) else $error("base top bits set");
    property p_flags; {rx_watchdog_flag, tx_watchdog_flag} == {rx_cutoff, tx_cutoff};
    endproperty
    a_flags: assert property (p_flags) else $error("flag apart from cutoff");
    property p_rx_act; rx_cutoff |-> $past(proc_in.rx_active) && $past(proc_in.rx_active, 2);
    endproperty
    a_rx_act: assert property (p_rx_act) else $error("cutoff while idle");
    property p_va; table_base_valid == $past(proc_in.desc_va); endproperty
    a_va: assert property (p_va) else $error("base valid wrong");
    property p_base0; !table_base_valid |-> table_base_address == 30'h0; endproperty
    a_base0: assert property (p_base0) else $error("base shown unasked");
    property p_bl; wm && proc_in.rx_state != ncw_pkg::PS_STOPPED
        |=> $stable(mode.burst_limit) && $stable(mode.operating_mode); endproperty
    a_bl: assert property (p_bl) else $error("mode applied while running");
    property p_fc; wm && mode.operating_mode != ncw_pkg::OM_LOOPBACK
        |=> $stable(mode.force_collision); endproperty
    a_fc: assert property (p_fc) else $error("collision bit outside loopback");
    property p_sr; wm && csr_req.wdata[ncw_pkg::POS_SR] && !proc_in.rx_list_init
        |=> $stable(mode.rx_start_cmd); endproperty
    a_sr: assert property (p_sr) else $error("receive start without list");
    c_rx: cover property (rx_cutoff);
    c_tx: cover property (tx_cutoff);
    c_va: cover property (table_base_valid);
endmodule // ncw_ctrl_props
bind ncw_ctrl ncw_ctrl_props u_props (.clk(clk), .rst_b(rst_b), .csr_req(csr_req),
    .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .proc_in(proc_in), .mode(mode),
    .rx_cutoff(rx_cutoff), .tx_cutoff(tx_cutoff), .rx_watchdog_flag(rx_watchdog_flag),
    .tx_watchdog_flag(tx_watchdog_flag), .table_base_address(table_base_address),
    .table_base_valid(table_base_valid));

// ===== net_ctrl_mode_gate_and_watchdogs_tb.sv
// testbench for mode gating, page base and watchdogs
`timescale 1ns/1ps
module net_ctrl_mode_gate_and_watchdogs_tb;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    ncw_pkg::ncw_proc_in_t pi = '0;
    ncw_pkg::ncw_csr_req_t req;
    ncw_pkg::ncw_mode_t    mode;
    ncw_pkg::ncw_mode_t    mode_lo;
    logic [31:0]           rdata;
    logic                  rvalid, rx_cut, tx_cut, rx_flag, tx_flag, bva;
    logic [29:0]           base;
    int                    bad_count = 0;
    int                    samples_checked = 0;
    always #2.5 clk = ~clk;
    ncw_ctrl u_dut (.clk(clk), .rst_b(rst_b), .csr_req(req), .csr_rdata(rdata),
        .csr_rvalid(rvalid), .proc_in(pi), .mode(mode), .rx_cutoff(rx_cut),
        .tx_cutoff(tx_cut), .rx_watchdog_flag(rx_flag), .tx_watchdog_flag(tx_flag),
        .table_base_address(base), .table_base_valid(bva));
    ncw_host_model u_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    // second copy built with the other reset top bit, only its mode is watched
    ncw_ctrl #(.MODE_TOP_RESET(1'b0)) u_dut_lo (.clk(clk), .rst_b(rst_b), .csr_req('0),
        .csr_rdata(), .csr_rvalid(), .proc_in('0), .mode(mode_lo), .rx_cutoff(),
        .tx_cutoff(), .rx_watchdog_flag(), .tx_watchdog_flag(),
        .table_base_address(), .table_base_valid());
    // ****************************************
    // shared tasks
    // ****************************************
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        u_host.rd(a, d, ok);
        chk(ok, 1'b1);
        chk(d, exp);
    endtask
    task setp(input bit tx, input ncw_pkg::ncw_proc_t s, input logic init);
        @(posedge clk);
        if (tx) begin
            pi.tx_state <= s;
            pi.tx_list_init <= init;
        end else begin
            pi.rx_state <= s;
            pi.rx_list_init <= init;
        end
    endtask
    // runs one side active with a tick every per cycles until cutoff
    task automatic t_wd(input bit tx, input int lim, input int per);
        int n;
        n = 0;
        @(posedge clk);
        if (tx) pi.tx_active <= 1'b1;
        else pi.rx_active <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            pi.sclk_tick <= (n % per) == 0;
            #1;
        end while (n < 21000 && (tx ? tx_cut : rx_cut) !== 1'b1);
        if (n == 21000) begin
            bad_count++;
            end_of_test();
        end else begin
            chk(n, 16 * lim * per + 1);
            chk(tx ? tx_flag : rx_flag, 1'b1);
            @(posedge clk);
            pi.rx_active <= 1'b0;
            pi.tx_active <= 1'b0;
            pi.sclk_tick <= 1'b1;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_mode;
        rdchk(ncw_pkg::OFS_MODE, ncw_pkg::MODE_RESET_HI);
        chk(mode.ie, 1'b1);
        chk(mode_lo.ie, 1'b0);
        setp(0, ncw_pkg::PS_RUNNING, 1'b0);
        u_host.wr(ncw_pkg::OFS_MODE, 32'h81E0F100);
        chk(mode.burst_limit, 2'h3);
        rdchk(ncw_pkg::OFS_MODE, 32'h81E0F100);
        setp(0, ncw_pkg::PS_STOPPED, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk(mode.operating_mode, 2'h0);
        u_host.wr(ncw_pkg::OFS_MODE, 32'h81E0F140);
        chk(mode.burst_limit, 2'h1);
        chk(mode.force_collision, 1'b0);
        u_host.wr(ncw_pkg::OFS_MODE, 32'h81E0F140);
        chk(mode.force_collision, 1'b1);
    endtask
    task automatic t_start(input bit tx);
        logic [31:0] mv;
        mv = 32'h81E0F140;
        u_host.wr(ncw_pkg::OFS_MODE, mv | (32'h1 << (tx ? ncw_pkg::POS_ST : ncw_pkg::POS_SR)));
        chk(tx ? mode.tx_start_cmd : mode.rx_start_cmd, 1'b0);
        setp(tx, ncw_pkg::PS_STOPPED, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(tx ? mode.tx_start_cmd : mode.rx_start_cmd, 1'b0);
        u_host.wr(ncw_pkg::OFS_MODE, mv | (32'h1 << (tx ? ncw_pkg::POS_ST : ncw_pkg::POS_SR)));
        chk(tx ? mode.tx_start_cmd : mode.rx_start_cmd, 1'b1);
        u_host.wr(ncw_pkg::OFS_MODE, mv);
        chk(tx ? mode.tx_start_cmd : mode.rx_start_cmd, 1'b1);
        setp(tx, ncw_pkg::PS_SUSPENDED, 1'b1);
        u_host.wr(ncw_pkg::OFS_MODE, mv);
        chk(tx ? mode.tx_start_cmd : mode.rx_start_cmd, 1'b0);
        setp(tx, ncw_pkg::PS_STOPPED, 1'b0);
    endtask
    task t_base;
        u_host.wr(ncw_pkg::OFS_BASE, 32'hFFFFFFFF);
        rdchk(ncw_pkg::OFS_BASE, 32'h3FFFFFFF);
        chk(base, 32'h0);
        chk(bva, 1'b0);
        @(posedge clk);
        pi.desc_va <= 1'b1;
        @(posedge clk);
        #1;
        chk(base, 32'h3FFFFFFF);
        chk(bva, 1'b1);
        @(posedge clk);
        pi.desc_va <= 1'b0;
        u_host.wr(ncw_pkg::OFS_RSVD, 32'hFFFFFFFF);
        rdchk(ncw_pkg::OFS_RSVD, 32'h0);
    endtask
    task t_watch;
        rdchk(ncw_pkg::OFS_WDOG, ncw_pkg::WDOG_RESET);
        t_wd(1, ncw_pkg::WD_DEFAULT, 1);
        u_host.wr(ncw_pkg::OFS_WDOG, 32'h0001002C);
        rdchk(ncw_pkg::OFS_WDOG, 32'h0001002C);
        t_wd(0, ncw_pkg::WD_MIN, 1);
        t_wd(0, ncw_pkg::WD_MIN, 2);
        t_wd(1, ncw_pkg::WD_MIN, 1);
        @(posedge clk);
        pi.rx_active <= 1'b1;
        repeat (400) @(posedge clk);
        pi.rx_active <= 1'b0;
        t_wd(0, ncw_pkg::WD_MIN, 1);
        setp(0, ncw_pkg::PS_RUNNING, 1'b0);
        u_host.wr(ncw_pkg::OFS_WDOG, 32'h00500000);
        rdchk(ncw_pkg::OFS_WDOG, 32'h00010000);
        setp(0, ncw_pkg::PS_STOPPED, 1'b0);
        setp(1, ncw_pkg::PS_RUNNING, 1'b0);
        u_host.wr(ncw_pkg::OFS_WDOG, 32'h00020050);
        rdchk(ncw_pkg::OFS_WDOG, 32'h00020000);
        setp(1, ncw_pkg::PS_STOPPED, 1'b0);
        pi.tx_active <= 1'b1;
        repeat (1000) begin
            @(posedge clk);
            #1;
            if (tx_cut !== 1'b0) chk(tx_cut, 1'b0);
        end
        chk(tx_flag, 1'b0);
        @(posedge clk);
        pi.tx_active <= 1'b0;
    endtask
    // reset in mid-run brings back reset readback and the default receive timeout
    task t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(ncw_pkg::OFS_WDOG, ncw_pkg::WDOG_RESET);
        rdchk(ncw_pkg::OFS_MODE, ncw_pkg::MODE_RESET_HI);
        t_wd(0, ncw_pkg::WD_DEFAULT, 1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        pi.sclk_tick <= 1'b1;
        t_mode;
        t_start(0);
        t_start(1);
        t_base;
        t_watch;
        t_reset;
        end_of_test;
    end
endmodule // net_ctrl_mode_gate_and_watchdogs_tb
